// File: cpu_decode_pkg.sv
// Shared constants and types for the instruction decoder and move core.
// Assumes one clock domain and a 16-bit instruction fetch stream.
package cpu_decode_pkg;
   // Instruction word fields
   localparam int OPC_MSB  = 15;
   localparam int OPC_LSB  = 10;
   localparam int SIZE_BIT = 9;
   localparam int MODE_MSB = 8;
   localparam int MODE_LSB = 6;
   localparam int RA_MSB   = 5;
   localparam int RA_LSB   = 3;
   localparam int RB_MSB   = 2;
   localparam int RB_LSB   = 0;

   // Type codes, grouped by class in ascending ranges
   localparam logic [5:0] TYPE_COUNT   = 6'h39;
   localparam logic [5:0] T_MOVE       = 6'h00;
   localparam logic [5:0] T_SYNC_STORE = 6'h01;
   localparam logic [5:0] T_SYNC_LOAD  = 6'h02;
   localparam logic [5:0] BASE_ARITH   = 6'h03;
   localparam logic [5:0] BASE_LOGIC   = 6'h11;
   localparam logic [5:0] BASE_SHIFT   = 6'h15;
   localparam logic [5:0] BASE_BIT     = 6'h1D;
   localparam logic [5:0] BASE_BRANCH  = 6'h2B;
   localparam logic [5:0] BASE_SYSTEM  = 6'h30;
   localparam logic [5:0] T_BLOCK_COPY = 6'h38;

   // Opcodes above the type range that alias the move type
   localparam logic [5:0] OPC_MOVE_STORE = 6'h39;
   localparam logic [5:0] OPC_PUSH       = 6'h3A;
   localparam logic [5:0] OPC_POP        = 6'h3B;

   // Addressing constants and reset values
   localparam logic [2:0]  STACK_REG      = 3'h7;
   localparam logic [7:0]  SHORT_ABS_HIGH = 8'hFF;
   localparam logic [15:0] STEP_BYTE      = 16'h0001;
   localparam logic [15:0] STEP_WORD      = 16'h0002;
   localparam logic [15:0] REG_RESET      = 16'h0000;
   localparam logic [3:0]  FLAGS_RESET    = 4'h0;

   typedef enum logic [2:0] {
      C_TRANSFER = 3'b000, C_ARITH  = 3'b001, C_LOGIC  = 3'b010,
      C_SHIFT    = 3'b011, C_BIT    = 3'b100, C_BRANCH = 3'b101,
      C_SYSTEM   = 3'b110, C_BLOCK  = 3'b111
   } class_type;

   typedef enum logic [2:0] {
      M_REG     = 3'b000, M_IND    = 3'b001, M_DISP  = 3'b010,
      M_POSTINC = 3'b011, M_PREDEC = 3'b100, M_ABS8  = 3'b101,
      M_ABS16   = 3'b110, M_IMM    = 3'b111
   } mode_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_DECODE = 3'b001, S_EXT = 3'b010,
      S_EXEC = 3'b011, S_MEM    = 3'b100
   } state_type;
endpackage: cpu_decode_pkg

// File: decode_if.sv
// Decode and address signals shared by the core and its two helpers.
// Assumes the core drives instr, baseVal and extWord from registers.
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
   import cpu_decode_pkg::*;
   logic [15:0] instr;
   logic [5:0]  typeCode;
   class_type   classCode;
   logic        isMove;
   logic        isStore;
   logic        illegal;
   logic        unsupported;
   logic        needsExt;
   mode_type    moveMode;
   logic        moveWord;
   logic [2:0]  addrReg;
   logic [2:0]  dataReg;
   logic [15:0] baseVal;
   logic [15:0] extWord;
   logic [15:0] effAddr;
   logic [15:0] newBase;
   logic        baseWrite;
   modport classify (input instr, output typeCode, classCode, isMove,
      isStore, illegal, unsupported, needsExt, moveMode, moveWord,
      addrReg, dataReg);
   modport address (input moveMode, moveWord, baseVal, extWord,
      output effAddr, newBase, baseWrite);
   modport core (output instr, baseVal, extWord, input typeCode,
      classCode, isMove, isStore, illegal, unsupported, needsExt,
      moveMode, moveWord, addrReg, dataReg, effAddr, newBase, baseWrite);
endinterface: decode_if
`default_nettype wire

// File: instr_classify.sv
// Combinational opcode classifier and move-form legality check.
// Assumes instr holds a stable instruction word from the core.
`timescale 1ns/1ps
`default_nettype none
module instr_classify
   import cpu_decode_pkg::*;
(
   // Decode signals
   decode_if.classify d
);
   // Class from type range; used for every decoded word
   function automatic class_type classOf(input logic [5:0] t);
      if (t < BASE_ARITH)        classOf = C_TRANSFER;
      else if (t < BASE_LOGIC)   classOf = C_ARITH;
      else if (t < BASE_SHIFT)   classOf = C_LOGIC;
      else if (t < BASE_BIT)     classOf = C_SHIFT;
      else if (t < BASE_BRANCH)  classOf = C_BIT;
      else if (t < BASE_SYSTEM)  classOf = C_BRANCH;
      else if (t < T_BLOCK_COPY) classOf = C_SYSTEM;
      else                       classOf = C_BLOCK;
   endfunction: classOf

   logic [5:0] opc;
   logic [5:0] t;
   mode_type   m;
   logic       w;
   logic       st;

   // Aliases fold onto the move type; push and pop are forced forms
   always_comb begin
      opc = d.instr[OPC_MSB:OPC_LSB];
      t = (opc >= TYPE_COUNT) ? T_MOVE : opc;
      m = mode_type'(d.instr[MODE_MSB:MODE_LSB]);
      w = d.instr[SIZE_BIT];
      st = (opc == OPC_MOVE_STORE) || (opc == OPC_PUSH);
      d.addrReg = d.instr[RA_MSB:RA_LSB];
      d.dataReg = d.instr[RB_MSB:RB_LSB];
      if (opc == OPC_PUSH || opc == OPC_POP) begin
         m = (opc == OPC_PUSH) ? M_PREDEC : M_POSTINC;
         w = 1'b1;
         d.addrReg = STACK_REG;
      end
      d.typeCode = t;
      d.classCode = classOf(t);
      d.isMove = (t == T_MOVE) && (opc <= OPC_POP);
      d.isStore = st;
      d.moveMode = m;
      d.moveWord = w;
      d.unsupported = (t == T_SYNC_STORE) || (t == T_SYNC_LOAD);
      d.illegal = opc > OPC_POP;
      if (d.isMove) begin
         if (m == M_ABS8 && w) d.illegal = 1'b1;
         if ((m == M_PREDEC || m == M_POSTINC) && !w
             && d.addrReg == STACK_REG) d.illegal = 1'b1;
         // Stores lack register, immediate and post-increment forms
         if (st && (m == M_REG || m == M_IMM || m == M_POSTINC))
            d.illegal = 1'b1;
         if (!st && m == M_PREDEC) d.illegal = 1'b1;
      end
      d.needsExt = d.isMove && (m == M_DISP || m == M_ABS8 ||
                   m == M_ABS16 || m == M_IMM);
   end
endmodule: instr_classify
`default_nettype wire

// File: move_address.sv
// Effective address and base register step for move operands.
// Assumes mode and size are already checked for legality.
`timescale 1ns/1ps
`default_nettype none
module move_address
   import cpu_decode_pkg::*;
(
   // Address signals
   decode_if.address a
);
   logic [15:0] step;
   logic [15:0] raw;

   // Word accesses drop address bit 0 and hit the even word below
   always_comb begin
      step = a.moveWord ? STEP_WORD : STEP_BYTE;
      a.newBase = a.baseVal;
      a.baseWrite = 1'b0;
      unique case (a.moveMode)
         M_DISP:  raw = a.baseVal + a.extWord;
         M_POSTINC: begin
            raw = a.baseVal;
            a.newBase = a.baseVal + step;
            a.baseWrite = 1'b1;
         end
         M_PREDEC: begin
            raw = a.baseVal - step;
            a.newBase = raw;
            a.baseWrite = 1'b1;
         end
         M_ABS8:  raw = {SHORT_ABS_HIGH, a.extWord[7:0]};
         M_ABS16: raw = a.extWord;
         default: raw = a.baseVal;
      endcase
      a.effAddr = {raw[15:1], raw[0] & ~a.moveWord};
   end
endmodule: move_address
`default_nettype wire

// File: cpu_instruction_class_and_data_move.sv
// Instruction decoder with execution of the data move group.
// Assumes a same-clock fetch stream and a same-clock memory bus that
// answers each request with a one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_class_and_data_move
   import cpu_decode_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Instruction fetch stream
   input  wire logic        instrValid,
   input  wire logic [15:0] instrWord,
   output logic             instrReady,
   // Operand memory bus
   output logic             memReq,
   output logic             memWrite,
   output logic             memWord,
   output logic [15:0]      memAddr,
   output logic [15:0]      memWdata,
   input  wire logic [15:0] memRdata,
   input  wire logic        memAck,
   // Decode report
   output logic             otherValid,
   output logic [5:0]       typeOut,
   output logic [2:0]       classOut,
   output logic             moveDone,
   output logic             trapIllegal,
   output logic             trapUnsupported,
   // Condition flags
   output logic             flagN,
   output logic             flagZ,
   output logic             flagV,
   output logic             flagC,
   // Register observation
   input  wire logic [2:0]  dbgSel,
   output logic [15:0]      dbgData
);
   // Control state
   state_type   state_reg, state_next;
   logic [15:0] ir_reg, ir_next;
   logic [15:0] ext_reg, ext_next;
   logic        ready_reg, ready_next;
   logic        memReq_reg, memReq_next;
   logic        memWrite_reg, memWrite_next;
   logic        memWord_reg, memWord_next;
   logic [15:0] memAddr_reg, memAddr_next;
   logic [15:0] memWdata_reg, memWdata_next;
   logic        other_reg, other_next;
   logic [5:0]  type_reg, type_next;
   class_type   class_reg, class_next;
   logic        done_reg, done_next;
   logic        trapIll_reg, trapIll_next;
   logic        trapUns_reg, trapUns_next;
   logic [3:0]  flags_reg, flags_next;

   // Register file write ports
   logic        aWr;
   logic [15:0] aData;
   logic        bWr;
   logic        bWord;
   logic [15:0] bData;

   // Register file state
   logic [15:0] regs_reg [8];
   logic [15:0] regs_next [8];
   logic [15:0] dbg_reg, dbg_next;

   decode_if dec ();

   // Opcode classification
   instr_classify classifier (
      .d (dec.classify)
   );

   // Operand address generation
   move_address addresser (
      .a (dec.address)
   );

   // Decode always looks at the held word, so it stays valid to the end
   assign dec.instr   = ir_reg;
   assign dec.extWord = ext_reg;
   assign dec.baseVal = regs_reg[dec.addrReg];

   // Negative and zero from the moved value at its own size
   function automatic logic [1:0] nzOf(
      input logic [15:0] v,
      input logic        w
   );
      if (w) nzOf = {v[15], v == 16'h0000};
      else   nzOf = {v[7], v[7:0] == 8'h00};
   endfunction: nzOf

   // Move flags; overflow cleared, carry kept
   function automatic logic [3:0] moveFlags(
      input logic [15:0] v,
      input logic        w,
      input logic        c
   );
      moveFlags = {nzOf(v, w), 1'b0, c};
   endfunction: moveFlags

   // Next control values
   always_comb begin
      state_next    = state_reg;
      ir_next       = ir_reg;
      ext_next      = ext_reg;
      ready_next    = ready_reg;
      memReq_next   = memReq_reg;
      memWrite_next = memWrite_reg;
      memWord_next  = memWord_reg;
      memAddr_next  = memAddr_reg;
      memWdata_next = memWdata_reg;
      type_next     = type_reg;
      class_next    = class_reg;
      flags_next    = flags_reg;
      other_next    = 1'b0;
      done_next     = 1'b0;
      trapIll_next  = 1'b0;
      trapUns_next  = 1'b0;
      aWr           = 1'b0;
      aData         = dec.newBase;
      bWr           = 1'b0;
      bWord         = dec.moveWord;
      bData         = memRdata;
      unique case (state_reg)
         S_IDLE: begin
            if (instrValid && ready_reg) begin
               ir_next    = instrWord;
               ready_next = 1'b0;
               state_next = S_DECODE;
            end
         end
         S_DECODE: begin
            type_next  = dec.typeCode;
            class_next = dec.classCode;
            if (dec.illegal) begin
               // Bad forms trap rather than guess at an access
               trapIll_next = 1'b1;
               ready_next   = 1'b1;
               state_next   = S_IDLE;
            end else if (dec.unsupported) begin
               trapUns_next = 1'b1;
               ready_next   = 1'b1;
               state_next   = S_IDLE;
            end else if (!dec.isMove) begin
               // Other classes are handed on to their own units
               other_next = 1'b1;
               ready_next = 1'b1;
               state_next = S_IDLE;
            end else if (dec.needsExt) begin
               ready_next = 1'b1;
               state_next = S_EXT;
            end else begin
               state_next = S_EXEC;
            end
         end
         S_EXT: begin
            // Second word: displacement, address or immediate
            if (instrValid && ready_reg) begin
               ext_next   = instrWord;
               ready_next = 1'b0;
               state_next = S_EXEC;
            end
         end
         S_EXEC: begin
            if (dec.moveMode == M_REG || dec.moveMode == M_IMM) begin
               // Register or immediate source, done in one cycle
               bWr = 1'b1;
               bData = (dec.moveMode == M_IMM) ? ext_reg
                                               : dec.baseVal;
               flags_next = moveFlags(bData, bWord, flags_reg[0]);
               done_next  = 1'b1;
               ready_next = 1'b1;
               state_next = S_IDLE;
            end else begin
               // Base register steps now; the address used is fixed
               memReq_next   = 1'b1;
               memWrite_next = dec.isStore;
               memWord_next  = dec.moveWord;
               memAddr_next  = dec.effAddr;
               memWdata_next = regs_reg[dec.dataReg];
               aWr           = dec.baseWrite;
               state_next    = S_MEM;
            end
         end
         S_MEM: begin
            if (memAck) begin
               memReq_next = 1'b0;
               if (!memWrite_reg) begin
                  // Load data lands after the step, so it wins
                  bWr = 1'b1;
                  flags_next = moveFlags(memRdata, bWord,
                                         flags_reg[0]);
               end else begin
                  flags_next = moveFlags(memWdata_reg, memWord_reg,
                                         flags_reg[0]);
               end
               done_next  = 1'b1;
               ready_next = 1'b1;
               state_next = S_IDLE;
            end
         end
         default: begin
            ready_next = 1'b1;
            state_next = S_IDLE;
         end
      endcase
   end

   // Control registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg    <= S_IDLE;
         ir_reg       <= REG_RESET;
         ext_reg      <= REG_RESET;
         ready_reg    <= 1'b1;
         memReq_reg   <= 1'b0;
         memWrite_reg <= 1'b0;
         memWord_reg  <= 1'b0;
         memAddr_reg  <= REG_RESET;
         memWdata_reg <= REG_RESET;
         other_reg    <= 1'b0;
         type_reg     <= T_MOVE;
         class_reg    <= C_TRANSFER;
         done_reg     <= 1'b0;
         trapIll_reg  <= 1'b0;
         trapUns_reg  <= 1'b0;
         flags_reg    <= FLAGS_RESET;
      end else begin
         state_reg    <= state_next;
         ir_reg       <= ir_next;
         ext_reg      <= ext_next;
         ready_reg    <= ready_next;
         memReq_reg   <= memReq_next;
         memWrite_reg <= memWrite_next;
         memWord_reg  <= memWord_next;
         memAddr_reg  <= memAddr_next;
         memWdata_reg <= memWdata_next;
         other_reg    <= other_next;
         type_reg     <= type_next;
         class_reg    <= class_next;
         done_reg     <= done_next;
         trapIll_reg  <= trapIll_next;
         trapUns_reg  <= trapUns_next;
         flags_reg    <= flags_next;
      end
   end

   // Next register file; byte writes keep the upper half
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         regs_next[i] = regs_reg[i];
      end
      if (aWr) begin
         regs_next[dec.addrReg] = aData;
      end
      if (bWr) begin
         regs_next[dec.dataReg] = bWord ? bData
            : {regs_reg[dec.dataReg][15:8], bData[7:0]};
      end
      dbg_next = regs_reg[dbgSel];
   end

   // Register file storage
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            regs_reg[i] <= REG_RESET;
         end
         dbg_reg <= REG_RESET;
      end else begin
         for (int i = 0; i < 8; i++) begin
            regs_reg[i] <= regs_next[i];
         end
         dbg_reg <= dbg_next;
      end
   end

   // Outputs straight from flip-flops
   assign instrReady      = ready_reg;
   assign memReq          = memReq_reg;
   assign memWrite        = memWrite_reg;
   assign memWord         = memWord_reg;
   assign memAddr         = memAddr_reg;
   assign memWdata        = memWdata_reg;
   assign otherValid      = other_reg;
   assign typeOut         = type_reg;
   assign classOut        = class_reg;
   assign moveDone        = done_reg;
   assign trapIllegal     = trapIll_reg;
   assign trapUnsupported = trapUns_reg;
   assign flagN           = flags_reg[3];
   assign flagZ           = flags_reg[2];
   assign flagV           = flags_reg[1];
   assign flagC           = flags_reg[0];
   assign dbgData         = dbg_reg;
endmodule: cpu_instruction_class_and_data_move
`default_nettype wire

// File: cpu_move_assertions.sv
// Checker for the decoder and move core, watching top-level ports only.
// Assumes a single clock domain and the synchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
module cpu_move_assertions
   import cpu_decode_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Fetch and memory bus
   input wire logic        instrValid,
   input wire logic        instrReady,
   input wire logic        memReq,
   input wire logic        memWrite,
   input wire logic        memWord,
   input wire logic [15:0] memAddr,
   input wire logic [15:0] memWdata,
   input wire logic        memAck,
   // Decode report and flags
   input wire logic        otherValid,
   input wire logic [5:0]  typeOut,
   input wire logic [2:0]  classOut,
   input wire logic        moveDone,
   input wire logic        trapIllegal,
   input wire logic        flagZ,
   input wire logic        flagV,
   input wire logic        flagC
);
   logic zeroNow;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Class ranges rebuilt from the per-class type counts
   function automatic logic [2:0] cls(input logic [5:0] t);
      if (t < 6'h03) return C_TRANSFER;
      if (t < 6'h11) return C_ARITH;
      if (t < 6'h15) return C_LOGIC;
      if (t < 6'h1D) return C_SHIFT;
      if (t < 6'h2B) return C_BIT;
      if (t < 6'h30) return C_BRANCH;
      if (t < 6'h38) return C_SYSTEM;
      return C_BLOCK;
   endfunction: cls

   // Zero test of the stored value at its access size
   assign zeroNow = memWord ? (memWdata == 16'h0000)
                            : (memWdata[7:0] == 8'h00);

   sequence storeAck;
      memReq && memWrite && memAck;
   endsequence

   req_hold_a: assert property (memReq && !memAck |=> memReq
      && $stable(memAddr) && $stable(memWdata) && $stable(memWord))
      else $error("request changed before ack");
   req_done_a: assert property (memReq && memAck |=> !memReq && moveDone)
      else $error("ack not followed by done");
   word_even_a: assert property (memReq && memWord |-> !memAddr[0])
      else $error("odd word address");
   flag_v_a: assert property (moveDone |-> !flagV)
      else $error("overflow set by move");
   carry_keep_a: assert property (moveDone |-> $stable(flagC))
      else $error("carry changed by move");
   store_zero_a: assert property (storeAck |=> flagZ == $past(zeroNow))
      else $error("zero flag wrong after store");
   class_map_a: assert property (otherValid |-> typeOut < 6'h39
      && classOut == cls(typeOut)) else $error("class mismatch");
   take_drop_a: assert property (instrValid && instrReady |=> !instrReady)
      else $error("ready held after take");
   pulse_excl_a: assert property (moveDone |-> !otherValid && !trapIllegal)
      else $error("two result pulses");
endmodule: cpu_move_assertions
`default_nettype wire

// File: operand_memory.sv
// Byte-wide operand memory answering the core's request handshake.
// Assumes one outstanding request held until it is acknowledged.
`timescale 1ns/1ps
`default_nettype none
module operand_memory (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Request side
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic        memWord,
   input  wire logic [15:0] memAddr,
   input  wire logic [15:0] memWdata,
   input  wire logic [1:0]  ackDelay,
   // Answer side
   output logic [15:0]      memRdata,
   output logic             memAck
);
   logic [7:0] bytes [0:255];
   logic [1:0] waitCnt;
   logic [7:0] first;
   logic [7:0] second;

   // Word upper byte sits at the even address
   assign first  = memAddr[7:0];
   assign second = {memAddr[7:1], 1'b1};

   // Idle data toggles so a stale value never looks valid
   always @(posedge clock) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (rst) begin
         // Pattern the bench can recompute; one driver for every array
         for (int i = 0; i < 256; i++) bytes[i] <= 8'(i) ^ 8'hA5;
         memRdata <= 16'h5A5A;
         waitCnt <= 2'h0;
      end
      else if (memReq && !memAck) begin
         if (waitCnt != ackDelay) waitCnt <= waitCnt + 2'h1;
         else begin
            waitCnt <= 2'h0;
            memAck <= 1'b1;
            if (memWrite && memWord) begin
               bytes[first] <= memWdata[15:8];
               bytes[second] <= memWdata[7:0];
            end
            else if (memWrite) bytes[first] <= memWdata[7:0];
            else if (memWord) memRdata <= {bytes[first], bytes[second]};
            else memRdata <= {~bytes[first], bytes[first]};
         end
      end
   end
endmodule: operand_memory
`default_nettype wire

// File: test_cpu_instruction_class_and_data_move.sv
// Self-checking bench for the decoder and move core.
// Assumes operand_memory fills byte a with a xor A5.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_instruction_class_and_data_move;
   import cpu_decode_pkg::*;
   logic        clock, rst, instrValid, instrReady;
   logic [15:0] instrWord, memAddr, memWdata, memRdata, dbgData;
   logic        memReq, memWrite, memWord, memAck, otherValid;
   logic [5:0]  typeOut;
   logic [2:0]  classOut, dbgSel;
   logic        moveDone, trapIllegal, trapUnsupported;
   logic        flagN, flagZ, flagV, flagC;
   logic [1:0]  ackDelay;
   logic [3:0]  seen;
   int          num_errors, num_checks;

   cpu_instruction_class_and_data_move dut (.clock(clock), .rst(rst),
      .instrValid(instrValid), .instrWord(instrWord),
      .instrReady(instrReady), .memReq(memReq), .memWrite(memWrite),
      .memWord(memWord), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck), .otherValid(otherValid),
      .typeOut(typeOut), .classOut(classOut), .moveDone(moveDone),
      .trapIllegal(trapIllegal), .trapUnsupported(trapUnsupported),
      .flagN(flagN), .flagZ(flagZ), .flagV(flagV), .flagC(flagC),
      .dbgSel(dbgSel), .dbgData(dbgData));
   operand_memory mem (.clock(clock), .rst(rst), .memReq(memReq),
      .memWrite(memWrite), .memWord(memWord), .memAddr(memAddr),
      .memWdata(memWdata), .ackDelay(ackDelay), .memRdata(memRdata),
      .memAck(memAck));

   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask: check

   task end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask: end_sim

   // Expected class from the per-class type counts, in class order
   function automatic logic [2:0] classFor(int t);
      int counts [8] = '{3, 14, 4, 8, 14, 5, 8, 1};
      int limit = 0;
      classFor = 3'h0;
      for (int k = 0; k < 8; k++) begin
         limit += counts[k];
         if (t >= limit) classFor = 3'(k + 1);
      end
   endfunction: classFor

   function automatic logic [15:0] op(int o, int s, int m, int a, int b);
      return {6'(o), 1'(s), 3'(m), 3'(a), 3'(b)};
   endfunction: op

   // Word held from a falling edge until the core takes it
   task send(input logic [15:0] w);
      @(negedge clock);
      while (instrReady !== 1'b1) @(negedge clock);
      instrValid = 1'b1;
      instrWord = w;
      @(negedge clock);
      instrValid = 1'b0;
   endtask: send

   // Pulses packed as done, other, illegal, unsupported
   task run(input logic [15:0] w, input logic ext, input logic [15:0] e,
            input logic [3:0] want);
      send(w);
      if (ext) send(e);
      seen = 4'h0;
      for (int i = 0; i < 20 && seen == 4'h0; i++) begin
         @(negedge clock);
         seen = {moveDone, otherValid, trapIllegal, trapUnsupported};
      end
      check(16'(seen), 16'(want));
   endtask: run

   task rd(input logic [2:0] r, input logic [15:0] exp);
      @(negedge clock);
      dbgSel = r;
      repeat (2) @(negedge clock);
      check(dbgData, exp);
   endtask: rd

   task t_reset;
      check(16'({instrReady, flagN, flagZ, flagV, flagC}), 16'h0010);
      rd(3'h7, 16'h0000);
   endtask: t_reset

   task t_classes;
      for (int t = 3; t < 57; t++) begin
         run(op(t, 0, 0, 0, 0), 1'b0, 16'h0000, 4'h4);
         check(16'(typeOut), 16'(t));
         check(16'(classOut), 16'(classFor(t)));
      end
      for (int t = 1; t < 3; t++) run(op(t, 0, 0, 0, 0), 1'b0, 16'h0, 4'h1);
      for (int t = 60; t < 64; t++) run(op(t, 0, 0, 0, 0), 1'b0, 16'h0, 4'h2);
   endtask: t_classes

   task t_moves;
      run(op(0, 1, 7, 0, 1), 1'b1, 16'h8000, 4'h8);
      check(16'({flagN, flagZ, flagV}), 16'h0004);
      run(op(0, 0, 7, 0, 2), 1'b1, 16'h0000, 4'h8);
      check(16'({flagN, flagZ, flagV}), 16'h0002);
      run(op(0, 1, 0, 1, 3), 1'b0, 16'h0000, 4'h8);
      rd(3'h3, 16'h8000);
   endtask: t_moves

   // Slow memory while the stack is exercised
   task t_stack;
      run(op(0, 1, 7, 0, 7), 1'b1, 16'h0100, 4'h8);
      ackDelay = 2'h3;
      run(op(58, 0, 0, 0, 3), 1'b0, 16'h0000, 4'h8);
      check(16'({flagN, flagZ, flagV}), 16'h0004);
      rd(3'h7, 16'h00FE);
      run(op(59, 0, 0, 0, 4), 1'b0, 16'h0000, 4'h8);
      rd(3'h4, 16'h8000);
      rd(3'h7, 16'h0100);
      ackDelay = 2'h0;
   endtask: t_stack

   task t_modes;
      run(op(0, 1, 7, 0, 5), 1'b1, 16'h0010, 4'h8);
      run(op(0, 0, 3, 5, 6), 1'b0, 16'h0000, 4'h8);
      rd(3'h6, 16'h00B5);
      rd(3'h5, 16'h0011);
      run(op(0, 1, 2, 5, 6), 1'b1, 16'h0000, 4'h8);
      rd(3'h6, 16'hB5B4);
      run(op(0, 0, 5, 0, 2), 1'b1, 16'h0020, 4'h8);
      rd(3'h2, 16'h0085);
      run(op(0, 1, 5, 0, 2), 1'b0, 16'h0000, 4'h2);
      run(op(57, 0, 4, 7, 1), 1'b0, 16'h0000, 4'h2);
      run(op(0, 1, 6, 0, 1), 1'b1, 16'h0040, 4'h8);
      rd(3'h1, 16'hE5E4);
      run(op(57, 1, 1, 5, 3), 1'b0, 16'h0000, 4'h8);
      run(op(0, 1, 1, 5, 1), 1'b0, 16'h0000, 4'h8);
      rd(3'h1, 16'h8000);
      run(op(57, 0, 4, 5, 2), 1'b0, 16'h0000, 4'h8);
      check(16'({flagN, flagZ, flagV}), 16'h0004);
      rd(3'h5, 16'h0010);
      run(op(0, 0, 1, 5, 6), 1'b0, 16'h0000, 4'h8);
      rd(3'h6, 16'hB585);
      run(op(0, 0, 4, 5, 1), 1'b0, 16'h0000, 4'h2);
      run(op(57, 1, 3, 5, 1), 1'b0, 16'h0000, 4'h2);
   endtask: t_modes

   // Main sequence after twelve reset cycles
   initial begin
      rst = 1'b1;
      instrValid = 1'b0;
      instrWord = 16'h0000;
      dbgSel = 3'h0;
      ackDelay = 2'h0;
      num_errors = 0;
      num_checks = 0;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      t_reset;
      t_classes;
      t_moves;
      t_stack;
      t_modes;
      end_sim;
   end

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      #200000;
      num_errors++;
      end_sim;
   end
endmodule: test_cpu_instruction_class_and_data_move

bind cpu_instruction_class_and_data_move cpu_move_assertions chk (
   .clock(clock), .rst(rst), .instrValid(instrValid),
   .instrReady(instrReady), .memReq(memReq), .memWrite(memWrite),
   .memWord(memWord), .memAddr(memAddr), .memWdata(memWdata),
   .memAck(memAck), .otherValid(otherValid), .typeOut(typeOut),
   .classOut(classOut), .moveDone(moveDone), .trapIllegal(trapIllegal),
   .flagZ(flagZ), .flagV(flagV), .flagC(flagC));
`default_nettype wire
